/* File: bnkrf_core.v */
// Purpose: mode-banked register file and processor state of the core
// Assumes: datapath and decoder drive one-cycle request pulses on mclk
// Notes:   read data appear one cycle after the index is given
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bnkrf_defs.vh"

module bnkrf_core (
   // clock and reset
   input  wire        mclk,
   input  wire        srst,
   // register read ports
   input  wire [3:0]  rdIdxA,
   input  wire [3:0]  rdIdxB,
   output reg  [31:0] rdDataA_reg,
   output reg  [31:0] rdDataB_reg,
   // register write port
   input  wire        wrEn,
   input  wire [3:0]  wrIdx,
   input  wire [31:0] wrData,
   // program counter and branches
   input  wire        pcWrEn,
   input  wire [31:0] pcWrData,
   input  wire        linkEn,
   input  wire        exchEn,
   input  wire [31:0] exchTarget,
   // exceptions
   input  wire        excEn,
   input  wire [4:0]  excMode,
   input  wire [31:0] excVector,
   input  wire [31:0] excLinkAddr,
   input  wire        retEn,
   input  wire [31:0] retAddr,
   // status word updates
   input  wire        flagsWrEn,
   input  wire [4:0]  flagsIn,
   input  wire        statWrEn,
   input  wire [31:0] statWrData,
   input  wire        savedWrEn,
   input  wire [31:0] savedWrData,
   // instruction fetch
   input  wire [31:0] fetchWord,
   output reg  [31:0] instr_reg,
   // data access
   input  wire        memReqEn,
   input  wire [31:0] memAddr,
   input  wire [1:0]  memSize,
   input  wire [31:0] memStoreData,
   input  wire [31:0] memBusWord,
   output reg  [31:0] memWordAddr_reg,
   output reg  [31:0] memLaneData_reg,
   output reg  [3:0]  memByteEn_reg,
   output reg  [31:0] memLoadData_reg,
   output reg         memMisalign_reg,
   // state view
   output reg  [31:0] pc_reg,
   output reg  [31:0] currentStatusWord_reg,
   output reg  [31:0] savedStatusWord_reg,
   output reg         compactState_reg,
   output reg         privileged_reg,
   // software port
   input  wire [7:0]  swAddr,
   input  wire [31:0] swWrData,
   input  wire        swWr,
   input  wire        swRd,
   output reg  [31:0] swRdData_reg
);

   // physical storage: slot 15 is the program counter
   reg [31:0] gprReg [0:`BNKRF_NGPR-1];
   reg [31:0] savedReg [0:`BNKRF_NSPSR-1];
   reg [31:0] statusReg;
   reg        bigEndReg;
   integer    i;

   wire [4:0]  curMode = statusReg[`BNKRF_MODE];
   wire        curT = statusReg[`BNKRF_BIT_T];
   wire [31:0] laneData;
   wire [3:0]  byteEn;
   wire [31:0] loadData;
   wire        misaligned;

   // architectural index plus mode to physical slot
   function [4:0] physIdx;
      input [3:0] idx;
      input [4:0] mode;
      reg   [4:0] base;
      begin
         base = `BNKRF_P_PC;
         case (mode)
            `BNKRF_MODE_SVC: base = `BNKRF_P_SVC;
            `BNKRF_MODE_ABT: base = `BNKRF_P_ABT;
            `BNKRF_MODE_IRQ: base = `BNKRF_P_IRQ;
            `BNKRF_MODE_UND: base = `BNKRF_P_UND;
            default:         base = `BNKRF_P_PC;
         endcase
         if (mode == `BNKRF_MODE_FIQ && idx >= `BNKRF_R8 &&
             idx != `BNKRF_R15) begin
            physIdx = `BNKRF_P_FIQ + {1'b0, idx - `BNKRF_R8};
         end else if (base != `BNKRF_P_PC && idx == `BNKRF_R13) begin
            physIdx = base;
         end else if (base != `BNKRF_P_PC && idx == `BNKRF_R14) begin
            physIdx = base + `BNKRF_P_STEP;
         end else begin
            physIdx = {1'b0, idx};
         end
      end
   endfunction

   // mode to saved status word slot; user, system and bad codes have none
   function [2:0] savedIdx;
      input [4:0] mode;
      begin
         case (mode)
            `BNKRF_MODE_FIQ: savedIdx = `BNKRF_S_FIQ;
            `BNKRF_MODE_SVC: savedIdx = `BNKRF_S_SVC;
            `BNKRF_MODE_ABT: savedIdx = `BNKRF_S_ABT;
            `BNKRF_MODE_IRQ: savedIdx = `BNKRF_S_IRQ;
            `BNKRF_MODE_UND: savedIdx = `BNKRF_S_UND;
            default:         savedIdx = `BNKRF_S_NONE;
         endcase
      end
   endfunction

   // any listed mode other than user is privileged
   function isPriv;
      input [4:0] mode;
      begin
         case (mode)
            `BNKRF_MODE_FIQ, `BNKRF_MODE_IRQ, `BNKRF_MODE_SVC,
            `BNKRF_MODE_ABT, `BNKRF_MODE_UND,
            `BNKRF_MODE_SYS: isPriv = 1'b1;
            default:         isPriv = 1'b0;
         endcase
      end
   endfunction

   // program counter alignment for the given state
   function [31:0] alignPc;
      input [31:0] addr;
      input        compact;
      begin
         if (compact) begin
            alignPc = addr & `BNKRF_HALIGN;
         end else begin
            alignPc = addr & `BNKRF_WALIGN;
         end
      end
   endfunction

   wire [2:0] curSaved = savedIdx(curMode);
   wire [2:0] excSaved = savedIdx(excMode);

   // byte lane steering for data accesses
   bnkrf_endian uEndian (
      .bigEnd     (bigEndReg),
      .addrLow    (memAddr[1:0]),
      .accSize    (memSize),
      .storeData  (memStoreData),
      .busWord    (memBusWord),
      .laneData   (laneData),
      .byteEn     (byteEn),
      .loadData   (loadData),
      .misaligned (misaligned)
   );

   // general registers, pc, status words; exception entry wins
   always @(posedge mclk) begin
      if (srst) begin
         for (i = 0; i < `BNKRF_NGPR; i = i + 1) begin
            gprReg[i] <= 32'h00000000;
         end
         for (i = 0; i < `BNKRF_NSPSR; i = i + 1) begin
            savedReg[i] <= 32'h00000000;
         end
         statusReg <= `BNKRF_STAT_RST;
      end else if (excEn) begin
         // save flags and mode, enter mode in full-width state
         if (excSaved != `BNKRF_S_NONE) begin
            savedReg[excSaved] <= statusReg;
         end
         statusReg[`BNKRF_MODE] <= excMode;
         statusReg[`BNKRF_BIT_T] <= 1'b0;
         statusReg[`BNKRF_BIT_IRQD] <= 1'b1;
         gprReg[physIdx(`BNKRF_R14, excMode)] <= excLinkAddr;
         gprReg[`BNKRF_P_PC] <= alignPc(excVector, 1'b0);
      end else if (retEn) begin
         // handler return brings back the saved state, compact included
         if (curSaved != `BNKRF_S_NONE) begin
            statusReg <= savedReg[curSaved];
            gprReg[`BNKRF_P_PC] <=
               alignPc(retAddr, savedReg[curSaved][`BNKRF_BIT_T]);
         end else begin
            gprReg[`BNKRF_P_PC] <= alignPc(retAddr, curT);
         end
      end else begin
         // ordinary write through the current bank
         if (wrEn && wrIdx != `BNKRF_R15) begin
            gprReg[physIdx(wrIdx, curMode)] <= wrData;
         end
         // link capture lands in r14 of the live bank
         if (linkEn) begin
            gprReg[physIdx(`BNKRF_R14, curMode)] <=
               gprReg[`BNKRF_P_PC];
         end
         // pc update; exchange swaps state and touches nothing else
         if (exchEn) begin
            statusReg[`BNKRF_BIT_T] <= exchTarget[0];
            gprReg[`BNKRF_P_PC] <= alignPc(exchTarget, exchTarget[0]);
         end else if (pcWrEn) begin
            gprReg[`BNKRF_P_PC] <= alignPc(pcWrData, curT);
         end else if (wrEn && wrIdx == `BNKRF_R15) begin
            gprReg[`BNKRF_P_PC] <= alignPc(wrData, curT);
         end
         // flags and mode of the current status word
         if (statWrEn) begin
            statusReg[`BNKRF_FLAGS] <= statWrData[`BNKRF_FLAGS];
            statusReg[`BNKRF_BIT_IRQD] <= statWrData[`BNKRF_BIT_IRQD];
            statusReg[`BNKRF_BIT_FIQD] <= statWrData[`BNKRF_BIT_FIQD];
            if (isPriv(statWrData[`BNKRF_MODE]) ||
                statWrData[`BNKRF_MODE] == `BNKRF_MODE_USR) begin
               statusReg[`BNKRF_MODE] <= statWrData[`BNKRF_MODE];
            end
         end else if (flagsWrEn) begin
            statusReg[`BNKRF_FLAGS] <= flagsIn;
         end
         // saved status word of the current mode only
         if (savedWrEn && curSaved != `BNKRF_S_NONE) begin
            savedReg[curSaved] <= savedWrData;
         end
      end
   end

   // registered read ports, banked by the mode in force now
   always @(posedge mclk) begin
      if (srst) begin
         rdDataA_reg <= 32'h00000000;
         rdDataB_reg <= 32'h00000000;
      end else begin
         rdDataA_reg <= gprReg[physIdx(rdIdxA, curMode)];
         rdDataB_reg <= gprReg[physIdx(rdIdxB, curMode)];
      end
   end

   // instruction pick: whole word, or the halfword chosen by pc bit 1 and the byte format
   always @(posedge mclk) begin
      if (srst) begin
         instr_reg <= 32'h00000000;
      end else if (!curT) begin
         instr_reg <= fetchWord;
      end else if (gprReg[`BNKRF_P_PC][`BNKRF_PCHALF] ^ bigEndReg) begin
         instr_reg <= {16'h0000, fetchWord[`BNKRF_UPPER]};
      end else begin
         instr_reg <= {16'h0000, fetchWord[`BNKRF_LOWER]};
      end
   end

   // data access: word address and steered lanes, held until next request
   always @(posedge mclk) begin
      if (srst) begin
         memWordAddr_reg <= 32'h00000000;
         memLaneData_reg <= 32'h00000000;
         memByteEn_reg <= 4'h0;
         memLoadData_reg <= 32'h00000000;
         memMisalign_reg <= 1'b0;
      end else if (memReqEn) begin
         memWordAddr_reg <= memAddr & `BNKRF_WALIGN;
         memLaneData_reg <= laneData;
         memByteEn_reg <= misaligned ? 4'h0 : byteEn;
         memLoadData_reg <= loadData;
         memMisalign_reg <= misaligned;
      end
   end

   // state view outputs
   always @(posedge mclk) begin
      if (srst) begin
         pc_reg <= 32'h00000000;
         currentStatusWord_reg <= `BNKRF_STAT_RST;
         savedStatusWord_reg <= 32'h00000000;
         compactState_reg <= 1'b0;
         privileged_reg <= 1'b1;
      end else begin
         pc_reg <= gprReg[`BNKRF_P_PC];
         currentStatusWord_reg <= statusReg;
         savedStatusWord_reg <= (curSaved == `BNKRF_S_NONE) ?
                                32'h00000000 : savedReg[curSaved];
         compactState_reg <= curT;
         privileged_reg <= isPriv(curMode);
      end
   end

   // software port: control write, state readback, unmapped reads zero
   always @(posedge mclk) begin
      if (srst) begin
         bigEndReg <= 1'b0;
         swRdData_reg <= 32'h00000000;
      end else begin
         if (swWr && swAddr == `BNKRF_A_CTRL) begin
            bigEndReg <= swWrData[`BNKRF_CTRL_BE];
         end
         swRdData_reg <= 32'h00000000;
         if (swRd) begin
            case (swAddr)
               `BNKRF_A_CTRL: swRdData_reg <= {31'h00000000, bigEndReg};
               `BNKRF_A_STAT: swRdData_reg <= statusReg;
               `BNKRF_A_SAVED: swRdData_reg <=
                  (curSaved == `BNKRF_S_NONE) ? 32'h00000000 :
                  savedReg[curSaved];
               `BNKRF_A_PC:   swRdData_reg <= gprReg[`BNKRF_P_PC];
               default:       swRdData_reg <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // bnkrf_core
`default_nettype wire

/* File: bnkrf_defs.vh */
// Purpose: shared constants of the banked register file
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef BNKRF_DEFS_VH
`define BNKRF_DEFS_VH

// mode field encodings
`define BNKRF_MODE_USR 5'h10
`define BNKRF_MODE_FIQ 5'h11
`define BNKRF_MODE_IRQ 5'h12
`define BNKRF_MODE_SVC 5'h13
`define BNKRF_MODE_ABT 5'h17
`define BNKRF_MODE_UND 5'h1B
`define BNKRF_MODE_SYS 5'h1F

// status word fields
`define BNKRF_FLAGS    31:27
`define BNKRF_BIT_IRQD 7
`define BNKRF_BIT_FIQD 6
`define BNKRF_BIT_T    5
`define BNKRF_MODE     4:0
`define BNKRF_STAT_RST 32'h000000D3

// architectural indices
`define BNKRF_R8  4'h8
`define BNKRF_R13 4'hD
`define BNKRF_R14 4'hE
`define BNKRF_R15 4'hF

// physical register slots
`define BNKRF_NGPR   31
`define BNKRF_NSPSR  5
`define BNKRF_P_PC   5'h0F
`define BNKRF_P_FIQ  5'h10
`define BNKRF_P_SVC  5'h17
`define BNKRF_P_ABT  5'h19
`define BNKRF_P_IRQ  5'h1B
`define BNKRF_P_UND  5'h1D
`define BNKRF_P_STEP 5'h01

// saved status word slots
`define BNKRF_S_FIQ  3'h0
`define BNKRF_S_SVC  3'h1
`define BNKRF_S_ABT  3'h2
`define BNKRF_S_IRQ  3'h3
`define BNKRF_S_UND  3'h4
`define BNKRF_S_NONE 3'h7

// alignment masks and halfword lanes
`define BNKRF_WALIGN 32'hFFFFFFFC
`define BNKRF_HALIGN 32'hFFFFFFFE
`define BNKRF_UPPER  31:16
`define BNKRF_LOWER  15:0
`define BNKRF_PCHALF 1

// data sizes
`define BNKRF_SZ_BYTE 2'h0
`define BNKRF_SZ_HALF 2'h1
`define BNKRF_SZ_WORD 2'h2

// software port offsets and control fields
`define BNKRF_A_CTRL 8'h00
`define BNKRF_A_STAT 8'h04
`define BNKRF_A_SAVED 8'h08
`define BNKRF_A_PC   8'h0C
`define BNKRF_CTRL_BE 0

`endif

/* File: bnkrf_endian.v */
// Purpose: byte lane steering between core data and the 32-bit bus
// Assumes: lane 0 is data lines 7..0, lane 3 is lines 31..24
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "bnkrf_defs.vh"

module bnkrf_endian (
   // format and access
   input  wire        bigEnd,
   input  wire [1:0]  addrLow,
   input  wire [1:0]  accSize,
   // data
   input  wire [31:0] storeData,
   input  wire [31:0] busWord,
   output reg  [31:0] laneData,
   output reg  [3:0]  byteEn,
   output reg  [31:0] loadData,
   output reg         misaligned
);

   reg [1:0] topOff;
   reg [1:0] lane;
   reg [4:0] shAmt;
   reg [31:0] mask;

   // lane of the lowest used byte lane for this access
   always @* begin
      topOff = 2'h0;
      mask = 32'h000000FF;
      byteEn = 4'h1;
      case (accSize)
         `BNKRF_SZ_HALF: begin
            topOff = 2'h1;
            mask = 32'h0000FFFF;
            byteEn = 4'h3;
         end
         `BNKRF_SZ_WORD: begin
            topOff = 2'h3;
            mask = 32'hFFFFFFFF;
            byteEn = 4'hF;
         end
         default: begin
            topOff = 2'h0;
         end
      endcase
      // byte 0 on lines 31..24 when big, lines 7..0 when little
      if (bigEnd) begin
         lane = 2'h3 - addrLow - topOff;
      end else begin
         lane = addrLow;
      end
      shAmt = {lane, 3'h0};
      byteEn = byteEn << lane;
      laneData = (storeData & mask) << shAmt;
      loadData = (busWord >> shAmt) & mask;
      // words on four bytes, halves on two, bytes anywhere
      case (accSize)
         `BNKRF_SZ_WORD: misaligned = |addrLow;
         `BNKRF_SZ_HALF: misaligned = addrLow[0];
         `BNKRF_SZ_BYTE: misaligned = 1'b0;
         default:        misaligned = 1'b1;
      endcase
   end

endmodule // bnkrf_endian
`default_nettype wire

/* File: bnkrf_mem_model.sv */
// Purpose: byte memory behind the fetch and data buses of the core
// Assumes: byte at address a holds a[7:0]
// Notes:   lane order follows the byte format chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module bnkrf_mem_model (
   // format and addresses
   input  wire logic        bigEnd,
   input  wire logic [31:0] fetchAddr,
   input  wire logic [31:0] dataAddr,
   // bus words
   output logic      [31:0] fetchWord,
   output logic      [31:0] busWord
);
   // byte k of a word on lane k, or on lane 3-k when big-endian
   function automatic logic [31:0] word(input logic [31:0] a);
      logic [7:0] b;
      b = {a[7:2], 2'h0};
      if (bigEnd)
         return {b, b + 8'h01, b + 8'h02, b + 8'h03};
      return {b + 8'h03, b + 8'h02, b + 8'h01, b};
   endfunction
   // both buses answer at once, no wait states
   assign fetchWord = word(fetchAddr);
   assign busWord   = word(dataAddr);
endmodule // bnkrf_mem_model
`default_nettype wire

/* File: bnkrf_core_sva.sv */
// Purpose: port-level checks of the banked register file
// Assumes: byte format mirrored from control writes
// Notes:   one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "bnkrf_defs.vh"
module bnkrf_core_sva (
   // clock and reset
   input wire logic        mclk,
   input wire logic        srst,
   // requests
   input wire logic        memReqEn,
   input wire logic [31:0] memAddr,
   input wire logic [1:0]  memSize,
   input wire logic        excEn,
   input wire logic [4:0]  excMode,
   input wire logic [7:0]  swAddr,
   input wire logic [31:0] swWrData,
   input wire logic        swWr,
   // outputs
   input wire logic [31:0] memWordAddr_reg,
   input wire logic [3:0]  memByteEn_reg,
   input wire logic        memMisalign_reg,
   input wire logic [31:0] pc_reg,
   input wire logic [31:0] currentStatusWord_reg,
   input wire logic [31:0] savedStatusWord_reg,
   input wire logic        compactState_reg,
   input wire logic        privileged_reg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic       bigFmt_reg;
   logic [3:0] laneEn;
   logic [4:0] mode;
   // format bit tracked from software writes
   always_ff @(posedge mclk)
      if (srst) bigFmt_reg <= 1'b0;
      else if (swWr && swAddr == `BNKRF_A_CTRL) bigFmt_reg <= swWrData[0];
   // lane of a byte access and current mode
   assign laneEn = bigFmt_reg ? 4'h8 >> memAddr[1:0] : 4'h1 << memAddr[1:0];
   assign mode = currentStatusWord_reg[4:0];
   sequence excTaken;
      excEn ##1 !excEn;
   endsequence
   privMode_a: assert property (
      privileged_reg == (mode != `BNKRF_MODE_USR)) else $error("priv bad");
   stateBit_a: assert property (
      compactState_reg == currentStatusWord_reg[5]) else $error("T bad");
   savedNone_a: assert property (
      mode == `BNKRF_MODE_USR || mode == `BNKRF_MODE_SYS
      |-> savedStatusWord_reg == 32'h0) else $error("saved word bad");
   wordMis_a: assert property (
      memReqEn && memSize == `BNKRF_SZ_WORD && memAddr[1:0] != 2'h0
      |=> memMisalign_reg && memByteEn_reg == 4'h0) else $error("mis bad");
   wordAddr_a: assert property (
      memReqEn |=> memWordAddr_reg == ($past(memAddr) & `BNKRF_WALIGN))
      else $error("word address bad");
   pcAlign_a: assert property (
      !pc_reg[0] && (compactState_reg || !pc_reg[1])) else $error("pc bad");
   excFull_a: assert property (
      excTaken |=> !compactState_reg && mode == $past(excMode, 2))
      else $error("exception state bad");
   byteLane_a: assert property (
      memReqEn && memSize == `BNKRF_SZ_BYTE
      |=> memByteEn_reg == $past(laneEn)) else $error("byte lane bad");
endmodule // bnkrf_core_sva
bind bnkrf_core bnkrf_core_sva u_bnkrf_core_sva (.mclk, .srst, .memReqEn,
   .memAddr, .memSize, .excEn, .excMode, .swAddr, .swWrData, .swWr,
   .memWordAddr_reg, .memByteEn_reg, .memMisalign_reg, .pc_reg,
   .currentStatusWord_reg, .savedStatusWord_reg, .compactState_reg,
   .privileged_reg);
`default_nettype wire

/* File: tb_bnkrf_core.sv */
// Purpose: self-checking bench of the banked register file
// Assumes: reset held twenty cycles, seed fixed
// Notes:   requests drop at the same edge that takes them
`timescale 1ns/1ps
`default_nettype none
`include "bnkrf_defs.vh"
module tb_bnkrf_core;
   // stimulus
   logic mclk = 1'b0, srst = 1'b1, bigEnd = 1'b0;
   logic [3:0] rdIdx = 4'h0, wrIdx = 4'h0;
   logic [4:0] excMode = 5'h00;
   logic [1:0] memSize = 2'h0;
   logic [7:0] swAddr = 8'h00;
   logic wrEn = 0, pcWrEn = 0, linkEn = 0, exchEn = 0, excEn = 0, retEn = 0;
   logic statWrEn = 0, memReqEn = 0, swWr = 0, swRd = 0, flagsWrEn = 0;
   logic [31:0] wrData = 0, pcWrData = 0, exchTarget = 0, excVector = 0;
   logic [31:0] excLink = 0, retAddr = 0, statWrData = 0, memAddr = 0;
   logic [31:0] memStore = 0, swWrData = 0;
   // observed
   wire logic [31:0] rdA, rdB, instr, fetchWord, busWord, wAddr, lane, load;
   wire logic [31:0] pc, curStat, saved, swRdData;
   wire logic [3:0]  byteEn;
   wire logic        misal, compact, priv;
   // bookkeeping
   logic [31:0] expReg [0:30];
   logic [15:0] seed = 16'hE285;
   int mismatches = 0;
   int checked = 0;
   localparam logic [4:0] MODES [0:6] = '{`BNKRF_MODE_USR, `BNKRF_MODE_FIQ,
      `BNKRF_MODE_IRQ, `BNKRF_MODE_SVC, `BNKRF_MODE_ABT, `BNKRF_MODE_UND,
      `BNKRF_MODE_SYS};
   bnkrf_core u_bnkrf_core (.mclk(mclk), .srst(srst), .rdIdxA(rdIdx),
      .rdIdxB(rdIdx), .rdDataA_reg(rdA), .rdDataB_reg(rdB), .wrEn(wrEn),
      .wrIdx(wrIdx), .wrData(wrData), .pcWrEn(pcWrEn), .pcWrData(pcWrData),
      .linkEn(linkEn), .exchEn(exchEn), .exchTarget(exchTarget),
      .excEn(excEn), .excMode(excMode), .excVector(excVector),
      .excLinkAddr(excLink), .retEn(retEn), .retAddr(retAddr),
      .flagsWrEn(flagsWrEn), .flagsIn(pcWrData[4:0]), .statWrEn(statWrEn),
      .statWrData(statWrData), .savedWrEn(1'b0), .savedWrData(32'h0),
      .fetchWord(fetchWord), .instr_reg(instr), .memReqEn(memReqEn),
      .memAddr(memAddr), .memSize(memSize), .memStoreData(memStore),
      .memBusWord(busWord), .memWordAddr_reg(wAddr), .memLaneData_reg(lane),
      .memByteEn_reg(byteEn), .memLoadData_reg(load),
      .memMisalign_reg(misal), .pc_reg(pc), .currentStatusWord_reg(curStat),
      .savedStatusWord_reg(saved), .compactState_reg(compact),
      .privileged_reg(priv), .swAddr(swAddr), .swWrData(swWrData),
      .swWr(swWr), .swRd(swRd), .swRdData_reg(swRdData));
   bnkrf_mem_model u_bnkrf_mem_model (.bigEnd(bigEnd), .fetchAddr(pc),
      .dataAddr(memAddr), .fetchWord(fetchWord), .busWord(busWord));
   // 100 MHz clock
   always #5 mclk = ~mclk;
   // compare and tally
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // next pseudo-random word
   function automatic logic [31:0] rnd();
      for (int k = 0; k < 2; k++) begin
         seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
         rnd = {rnd[15:0], seed};
      end
   endfunction
   // physical slot of an index in a mode
   function automatic int slot(input logic [4:0] m, input int i);
      int b;
      b = m == `BNKRF_MODE_SVC ? 23 : m == `BNKRF_MODE_ABT ? 25 :
          m == `BNKRF_MODE_IRQ ? 27 : m == `BNKRF_MODE_UND ? 29 : 0;
      if (m == `BNKRF_MODE_FIQ && i >= 8) return i + 8;
      if (b != 0 && i >= 13) return b + i - 13;
      return i;
   endfunction
   // take the request at the next edge, then drop every strobe
   task automatic go();
      @(posedge mclk);
      {wrEn, pcWrEn, linkEn, exchEn, excEn, retEn, flagsWrEn} <= 7'h00;
      {statWrEn, memReqEn, swWr, swRd} <= 4'h0;
      @(negedge mclk);
   endtask
   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      @(posedge mclk);
      wrEn <= 1'b1;
      wrIdx <= i;
      wrData <= d;
      go();
   endtask
   task automatic rd(input logic [3:0] i, input logic [31:0] exp);
      @(posedge mclk);
      rdIdx <= i;
      @(posedge mclk);
      @(negedge mclk);
      cmp(rdA, exp);
      cmp(rdB, exp);
   endtask
   // software port, read data checked in the cycle after the strobe
   task automatic sw(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      swWr <= w;
      swRd <= !w;
      swAddr <= a;
      swWrData <= d;
      go();
      if (!w) cmp(swRdData, d);
   endtask
   task automatic setMode(input logic [4:0] m, input logic [4:0] f);
      @(posedge mclk);
      statWrEn <= 1'b1;
      statWrData <= {f, 19'h0, 3'h6, m};
      go();
      @(negedge mclk);
      cmp(curStat, {f, 19'h0, 3'h6, m});
      cmp({31'h0, priv}, {31'h0, m != `BNKRF_MODE_USR});
   endtask
   // k: 0 exchange, 1 pc write, 2 link, 3 exception, 4 return, 5 flags
   task automatic ctl(input int k, input logic [31:0] d);
      @(posedge mclk);
      {exchEn, pcWrEn, linkEn, excEn, retEn, flagsWrEn} <= 6'h20 >> k;
      {exchTarget, pcWrData, excLink, retAddr} <= {4{d}};
      excMode <= `BNKRF_MODE_IRQ;
      excVector <= 32'h18;
      go();
      @(negedge mclk);
   endtask
   task automatic mem(input logic [31:0] a, input logic [1:0] s);
      logic [31:0] m, e;
      logic [7:0]  b;
      logic [3:0]  be;
      logic [2:0]  lo;
      logic        bad;
      bad = (s == 2'h2 && a[1:0] != 2'h0) || (s == 2'h1 && a[0]);
      lo = bigEnd ? 3'h4 - (3'h1 << s) - a[1:0] : {1'b0, a[1:0]};
      be = ((4'h1 << (3'h1 << s)) - 4'h1) << lo;
      m = ((32'h1 << (8 << s)) - 32'h1) << (8 * lo);
      b = s == 2'h0 ? a[7:0] : s == 2'h1 ? {a[7:1], 1'b0} : {a[7:2], 2'h0};
      e = s == 2'h0 ? {24'h0, b} : bigEnd ? (s == 2'h1 ? {16'h0, b, b + 8'h01}
          : {b, b + 8'h01, b + 8'h02, b + 8'h03}) : (s == 2'h1 ?
          {16'h0, b + 8'h01, b} : {b + 8'h03, b + 8'h02, b + 8'h01, b});
      @(posedge mclk);
      memReqEn <= 1'b1;
      memAddr <= a;
      memSize <= s;
      memStore <= rnd();
      go();
      cmp(wAddr, a & `BNKRF_WALIGN);
      cmp({31'h0, misal}, {31'h0, bad});
      cmp({28'h0, byteEn}, bad ? 32'h0 : {28'h0, be});
      if (!bad) cmp(lane & m, (memStore << (8 * lo)) & m);
      if (!bad) cmp(load, e);
   endtask
   // verdict
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      mismatches++;
      conclude();
   end
   // main sequence
   initial begin
      logic [31:0] v;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      cmp(curStat, `BNKRF_STAT_RST);
      cmp({31'h0, priv}, 32'h1);
      cmp({31'h0, compact}, 32'h0);
      sw(1'b0, `BNKRF_A_STAT, `BNKRF_STAT_RST);
      sw(1'b0, 8'h20, 32'h0);
      $display("reset test done");
      // every mode fills r0..r14, then every mode reads them back
      for (int m = 0; m < 7; m++) begin
         setMode(MODES[m], 5'h00);
         for (int i = 0; i < 15; i++) begin
            v = rnd();
            expReg[slot(MODES[m], i)] = v;
            wr(i[3:0], v);
         end
      end
      for (int m = 0; m < 7; m++) begin
         v = rnd();
         setMode(MODES[m], v[4:0]);
         for (int i = 0; i < 15; i++)
            rd(i[3:0], expReg[slot(MODES[m], i)]);
      end
      $display("banking test done");
      // both byte formats: state changes, exception, link, data lanes
      for (int i = 0; i < 2; i++) begin
         sw(1'b1, `BNKRF_A_CTRL, {31'h0, i[0]});
         sw(1'b0, `BNKRF_A_CTRL, {31'h0, i[0]});
         bigEnd = i[0];
         setMode(`BNKRF_MODE_USR, 5'h15);
         wr(4'h3, 32'h0000C0DE);
         ctl(0, 32'h00001237);
         cmp({31'h0, compact}, 32'h1);
         cmp(pc, 32'h00001236);
         cmp(curStat, 32'hA80000F0);
         rd(4'h3, 32'h0000C0DE);
         cmp(instr, i ? 32'h00003637 : 32'h00003736);
         v = rnd();
         ctl(3, v);
         cmp(curStat, 32'hA80000D2);
         cmp(saved, 32'hA80000F0);
         rd(4'hE, v);
         ctl(4, 32'h00001241);
         cmp(curStat, 32'hA80000F0);
         cmp(pc, 32'h00001240);
         ctl(2, 32'h0);
         rd(4'hE, 32'h00001240);
         ctl(0, 32'h00000100);
         ctl(1, 32'h00000203);
         ctl(5, 32'h0000000A);
         cmp(curStat, 32'h500000D0);
         sw(1'b0, `BNKRF_A_PC, 32'h00000200);
         mem(32'h00000007, `BNKRF_SZ_BYTE);
         mem(32'h00000006, `BNKRF_SZ_WORD);
         mem(32'h00000005, `BNKRF_SZ_HALF);
         repeat (24) begin
            v = rnd();
            mem(v, v[9:8] % 2'h3);
         end
         $display("format test done");
      end
      conclude();
   end
endmodule // tb_bnkrf_core
`default_nettype wire
